// ---- src/pm_pkg.sv ----
// Constants and types for the per-link performance monitor snapshot block.
// Assumes a 40 MHz core clock and a simple strobed register port.
// Function
// [RULE_01] All snapshot registers refresh in one cycle
// [RULE_02] Manual trigger rising edge refreshes the group
// [RULE_03] Auto enable refreshes the group every second
// [RULE_04] CRC-6 errors counted in ESF, ten bits
// [RULE_05] F-bit errors counted in SF/DM/SLC, twelve bits
// [RULE_06] ESF: same counter counts alignment bit errors
// [RULE_07] Alignment change events in three bits
// [RULE_08] Sync loss events in five bits
// [RULE_09] Pattern detector bit errors in sixteen bits
// [RULE_10] AMI decoding: bipolar violations, sixteen bits
// [RULE_11] B8ZS decoding: code violations, same counter
// [RULE_12] Digital data format: DDS pattern errors, ten bits
// [RULE_13] Split counters: LSB low address, MSB high
// [RULE_14] Refresh copies accumulators, restarts them, keeps events
// [RULE_15] Accumulators saturate instead of wrapping
package pm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map, indirect addresses
    localparam logic [7:0] PM_ADDR_CRC_LO   = 8'h00;
    localparam logic [7:0] PM_ADDR_CRC_HI   = 8'h01;
    localparam logic [7:0] PM_ADDR_FBE_LO   = 8'h02;
    localparam logic [7:0] PM_ADDR_FBE_HI   = 8'h03;
    localparam logic [7:0] PM_ADDR_ALIGN    = 8'h04;
    localparam logic [7:0] PM_ADDR_SYNC     = 8'h05;
    localparam logic [7:0] PM_ADDR_PAT_LO   = 8'h06;
    localparam logic [7:0] PM_ADDR_PAT_HI   = 8'h07;
    localparam logic [7:0] PM_ADDR_LCV_LO   = 8'h08;
    localparam logic [7:0] PM_ADDR_LCV_HI   = 8'h09;
    localparam logic [7:0] PM_ADDR_DDS_LO   = 8'h0a;
    localparam logic [7:0] PM_ADDR_DDS_HI   = 8'h0b;
    // Control and interrupt registers placed after the counter map
    localparam logic [7:0] PM_ADDR_CTRL     = 8'h10;
    localparam logic [7:0] PM_ADDR_IRQ_STAT = 8'h11;
    localparam logic [7:0] PM_ADDR_IRQ_MASK = 8'h12;
    localparam logic [7:0] PM_ADDR_MODE     = 8'h13;

    ////////////////////////////////////////////////////////////////////////
    // Field layout
    localparam int PM_CTRL_AUTO_BIT   = 0;
    localparam int PM_CTRL_MANUAL_BIT = 1;
    localparam int PM_CRC_HI_POS      = 4;
    localparam int PM_W_CRC   = 10;
    localparam int PM_W_FBE   = 12;
    localparam int PM_W_ALIGN = 3;
    localparam int PM_W_SYNC  = 5;
    localparam int PM_W_PAT   = 16;
    localparam int PM_W_LCV   = 16;
    localparam int PM_W_DDS   = 10;
    // Interrupt status bits
    localparam int PM_IRQ_SNAP_BIT = 0;
    localparam int PM_IRQ_SAT_BIT  = 1;
    localparam int PM_IRQ_W        = 2;
    localparam logic [7:0] PM_RESET_BYTE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing: one-second auto refresh at 40 MHz
    localparam longint PM_CLK_HZ     = 40_000_000;
    localparam longint PM_AUTO_SEC   = 1;
    localparam int     PM_AUTO_CYCLES = int'(PM_CLK_HZ * PM_AUTO_SEC);

    ////////////////////////////////////////////////////////////////////////
    // Framing format and line decoding modes
    typedef enum logic [1:0] {
        PM_FMT_SF   = 2'b00,
        PM_FMT_ESF  = 2'b01,
        PM_FMT_DIGITAL_DATA = 2'b10,
        PM_FMT_SLC  = 2'b11
    } pm_format_e;

    typedef enum logic {
        PM_DEC_AMI  = 1'b0,
        PM_DEC_B8ZS = 1'b1
    } pm_decode_e;

    // Event strobes from framer, line decoder and pattern detector
    typedef struct packed {
        logic crc6_err;
        logic fbit_err;
        logic align_bit_err;
        logic align_change;
        logic sync_loss;
        logic pattern_err;
        logic bipolar_viol;
        logic code_viol;
        logic dds_err;
    } pm_events_s;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pm_bus_s;

endpackage

// ---- src/pm_perf_monitor.sv ----
// Performance monitor counters with group snapshot for one receive link.
// Events are one-cycle pulses synchronous to core_clk_i; the register
// port is a simple strobed slave with read data one cycle after the read.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module pm_perf_monitor
    import pm_pkg::*;
#(
    parameter int AUTO_CYCLES = PM_AUTO_CYCLES
) (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire pm_bus_s    bus_i,
    output logic [7:0]      rdata_o,
    input  wire pm_events_s events_i,
    output logic            irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Saturating increment shared by every accumulator
    function automatic logic [15:0] sat_inc(input logic [15:0] v,
                                            input logic [15:0] vmax,
                                            input logic        ev);
        logic [15:0] r;
        r = v;
        if (ev && (v != vmax)) begin
            r = v + 16'h0001;
        end
        return r;
    endfunction

    function automatic logic [15:0] wmax(input int w);
        return 16'((32'h1 << w) - 1);
    endfunction

    // Next accumulator value: a refresh restarts the count but keeps an
    // event of the refresh cycle for the new interval; otherwise count up
    // and stick at all ones, so an overflowing interval never reads small
    function automatic logic [15:0] acc_next(input logic [15:0] v,
                                             input int          w,
                                             input logic        ev,
                                             input logic        refresh);
        logic [15:0] r;
        if (refresh) begin
            r = {15'h0000, ev}; // RULE_14
        end else begin
            r = sat_inc(v, wmax(w), ev); // RULE_15
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control and mode state
    logic             auto_en_r;
    logic             manual_bit_r;
    pm_format_e       format_r;
    pm_decode_e       decode_r;
    logic [PM_IRQ_W-1:0] irq_stat_r;
    logic [PM_IRQ_W-1:0] irq_mask_r;
    logic [31:0]      sec_cnt_r;
    logic             snap;
    logic             manual_rise;
    logic             tick;
    logic             wr_ctrl;

    assign wr_ctrl = bus_i.wr && (bus_i.addr == PM_ADDR_CTRL);
    // Only a 0 to 1 change of the manual bit refreshes
    assign manual_rise = wr_ctrl && !manual_bit_r
                         && bus_i.wdata[PM_CTRL_MANUAL_BIT]; // RULE_02
    assign tick = auto_en_r && (sec_cnt_r == 32'(AUTO_CYCLES - 1)); // RULE_03
    // One shared strobe keeps every snapshot on the same interval
    assign snap = manual_rise || tick; // RULE_01

    // Control register writes
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            auto_en_r    <= 1'b0;
            manual_bit_r <= 1'b0;
        end else if (wr_ctrl) begin
            auto_en_r    <= bus_i.wdata[PM_CTRL_AUTO_BIT];
            manual_bit_r <= bus_i.wdata[PM_CTRL_MANUAL_BIT];
        end
    end

    // Mode register: format in bits 1:0, decoding in bit 2
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            format_r <= PM_FMT_SF;
            decode_r <= PM_DEC_AMI;
        end else if (bus_i.wr && (bus_i.addr == PM_ADDR_MODE)) begin
            format_r <= pm_format_e'(bus_i.wdata[1:0]);
            decode_r <= pm_decode_e'(bus_i.wdata[2]);
        end
    end

    // One-second divider; restarts when auto refresh is off
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sec_cnt_r <= 32'h0000_0000;
        end else if (!auto_en_r || tick) begin
            sec_cnt_r <= 32'h0000_0000;
        end else begin
            sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Qualify events by mode
    logic ev_crc, ev_fbe, ev_align, ev_sync, ev_pat, ev_lcv, ev_dds;

    assign ev_crc = events_i.crc6_err && (format_r == PM_FMT_ESF); // RULE_04
    always_comb begin
        if (format_r == PM_FMT_ESF) begin
            ev_fbe = events_i.align_bit_err; // RULE_06
        end else begin
            ev_fbe = events_i.fbit_err; // RULE_05
        end
    end
    assign ev_align = events_i.align_change; // RULE_07
    assign ev_sync  = events_i.sync_loss; // RULE_08
    assign ev_pat   = events_i.pattern_err; // RULE_09
    always_comb begin
        if (decode_r == PM_DEC_B8ZS) begin
            ev_lcv = events_i.code_viol; // RULE_11
        end else begin
            ev_lcv = events_i.bipolar_viol; // RULE_10
        end
    end
    assign ev_dds = events_i.dds_err
                    && (format_r == PM_FMT_DIGITAL_DATA); // RULE_12

    ////////////////////////////////////////////////////////////////////////
    // Accumulators and snapshots
    logic [PM_W_CRC-1:0]   acc_crc_r,   snp_crc_r;
    logic [PM_W_FBE-1:0]   acc_fbe_r,   snp_fbe_r;
    logic [PM_W_ALIGN-1:0] acc_align_r, snp_align_r;
    logic [PM_W_SYNC-1:0]  acc_sync_r,  snp_sync_r;
    logic [PM_W_PAT-1:0]   acc_pat_r,   snp_pat_r;
    logic [PM_W_LCV-1:0]   acc_lcv_r,   snp_lcv_r;
    logic [PM_W_DDS-1:0]   acc_dds_r,   snp_dds_r;
    logic                  any_sat;

    // Saturation of any accumulator raises an interrupt event
    assign any_sat = (16'(acc_crc_r) == wmax(PM_W_CRC))
                  || (16'(acc_fbe_r) == wmax(PM_W_FBE))
                  || (16'(acc_align_r) == wmax(PM_W_ALIGN))
                  || (16'(acc_sync_r) == wmax(PM_W_SYNC))
                  || (acc_pat_r == wmax(PM_W_PAT))
                  || (acc_lcv_r == wmax(PM_W_LCV))
                  || (16'(acc_dds_r) == wmax(PM_W_DDS));

    // CRC-6 error accumulator; only fed in ESF
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_crc_r <= '0;
        end else begin
            acc_crc_r <= PM_W_CRC'(acc_next(16'(acc_crc_r),
                                   PM_W_CRC, ev_crc, snap)); // RULE_14
        end
    end

    // F-bit or alignment bit error accumulator
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_fbe_r <= '0;
        end else begin
            acc_fbe_r <= PM_W_FBE'(acc_next(16'(acc_fbe_r),
                                   PM_W_FBE, ev_fbe, snap));
        end
    end

    // Alignment change accumulator; three bits fill up quickly
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_align_r <= '0;
        end else begin
            acc_align_r <= PM_W_ALIGN'(acc_next(16'(acc_align_r),
                                       PM_W_ALIGN, ev_align, snap));
        end
    end

    // Sync loss accumulator
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_sync_r <= '0;
        end else begin
            acc_sync_r <= PM_W_SYNC'(acc_next(16'(acc_sync_r),
                                     PM_W_SYNC, ev_sync, snap));
        end
    end

    // Pattern detector bit error accumulator, full width of the function
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_pat_r <= '0;
        end else begin
            acc_pat_r <= acc_next(acc_pat_r, PM_W_PAT, ev_pat, snap);
        end
    end

    // Line violation accumulator, source picked by the decoding mode
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_lcv_r <= '0;
        end else begin
            acc_lcv_r <= acc_next(acc_lcv_r, PM_W_LCV, ev_lcv, snap);
        end
    end

    // DDS pattern error accumulator; only fed in digital data format
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_dds_r <= '0;
        end else begin
            acc_dds_r <= PM_W_DDS'(acc_next(16'(acc_dds_r),
                                   PM_W_DDS, ev_dds, snap));
        end
    end

    // Every snapshot loads on the one shared strobe, so the group
    // always describes the same interval
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            snp_crc_r <= '0;
        end else if (snap) begin
            snp_crc_r <= acc_crc_r; // RULE_01
        end
    end

    // F-bit or alignment bit error snapshot
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            snp_fbe_r <= '0;
        end else if (snap) begin
            snp_fbe_r <= acc_fbe_r;
        end
    end

    // Alignment change snapshot
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            snp_align_r <= '0;
        end else if (snap) begin
            snp_align_r <= acc_align_r;
        end
    end

    // Sync loss snapshot
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            snp_sync_r <= '0;
        end else if (snap) begin
            snp_sync_r <= acc_sync_r;
        end
    end

    // Pattern error snapshot; both bytes come from one load, no latching
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            snp_pat_r <= '0;
        end else if (snap) begin
            snp_pat_r <= acc_pat_r;
        end
    end

    // Line violation snapshot
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            snp_lcv_r <= '0;
        end else if (snap) begin
            snp_lcv_r <= acc_lcv_r;
        end
    end

    // DDS pattern error snapshot
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            snp_dds_r <= '0;
        end else if (snap) begin
            snp_dds_r <= acc_dds_r; // RULE_14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over a write-one clear in the same cycle
    logic [PM_IRQ_W-1:0] irq_set;
    assign irq_set = {any_sat, snap};

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_stat_r <= '0;
        end else begin
            if (bus_i.wr && (bus_i.addr == PM_ADDR_IRQ_STAT)) begin
                irq_stat_r <= (irq_stat_r & ~bus_i.wdata[PM_IRQ_W-1:0])
                              | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_mask_r <= '0;
        end else if (bus_i.wr && (bus_i.addr == PM_ADDR_IRQ_MASK)) begin
            irq_mask_r <= bus_i.wdata[PM_IRQ_W-1:0];
        end
    end

    // Registered so the pin comes straight from a flip-flop
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((irq_stat_r | irq_set) & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = PM_RESET_BYTE;
        case (bus_i.addr)
            PM_ADDR_CRC_LO:   rd_mux = snp_crc_r[7:0]; // RULE_13
            PM_ADDR_CRC_HI:   rd_mux = {2'b00, snp_crc_r[9:8], 4'h0};
            PM_ADDR_FBE_LO:   rd_mux = snp_fbe_r[7:0];
            PM_ADDR_FBE_HI:   rd_mux = {4'h0, snp_fbe_r[11:8]};
            PM_ADDR_ALIGN:    rd_mux = {5'b00000, snp_align_r};
            PM_ADDR_SYNC:     rd_mux = {3'b000, snp_sync_r};
            PM_ADDR_PAT_LO:   rd_mux = snp_pat_r[7:0];
            PM_ADDR_PAT_HI:   rd_mux = snp_pat_r[15:8];
            PM_ADDR_LCV_LO:   rd_mux = snp_lcv_r[7:0];
            PM_ADDR_LCV_HI:   rd_mux = snp_lcv_r[15:8];
            PM_ADDR_DDS_LO:   rd_mux = snp_dds_r[7:0];
            PM_ADDR_DDS_HI:   rd_mux = {6'b000000, snp_dds_r[9:8]};
            PM_ADDR_CTRL:     rd_mux = {6'b000000, manual_bit_r, auto_en_r};
            PM_ADDR_IRQ_STAT: rd_mux = {6'b000000, irq_stat_r};
            PM_ADDR_IRQ_MASK: rd_mux = {6'b000000, irq_mask_r};
            PM_ADDR_MODE:     rd_mux = {5'b00000, decode_r, format_r};
            default:          rd_mux = PM_RESET_BYTE;
        endcase
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= PM_RESET_BYTE;
        end else if (bus_i.rd) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= PM_RESET_BYTE;
        end
    end

endmodule

// ---- tb/pm_checker_properties.sv ----
// Checker for the perf monitor: readback and interrupt level.
// Sees only the top ports; bound to every pm_perf_monitor.
`timescale 1ns/1ps
module pm_checker
    import pm_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       reset_i,
    input wire pm_bus_s    bus_i,
    input wire logic [7:0] rdata_o,
    input wire pm_events_s events_i,
    input wire logic       irq_o
);
    logic [1:0] mask_r;
    logic [2:0] mode_r;
    logic [1:0] ctrl_r;
    logic [7:0] resv;
    logic       clr;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    ////////////////////////////////////////
    // Shadows of the writable registers
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mask_r <= 2'h0;
            mode_r <= 3'h0;
            ctrl_r <= 2'h0;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                PM_ADDR_CTRL:     ctrl_r <= bus_i.wdata[1:0];
                PM_ADDR_IRQ_MASK: mask_r <= bus_i.wdata[1:0];
                PM_ADDR_MODE:     mode_r <= bus_i.wdata[2:0];
                default:          ;
            endcase
        end
    end

    // Bits that must read zero; unmapped places read all zero
    always_comb begin
        case (bus_i.addr)
            PM_ADDR_CRC_HI: resv = 8'hcf;
            PM_ADDR_FBE_HI: resv = 8'hf0;
            PM_ADDR_ALIGN:  resv = 8'hf8;
            PM_ADDR_SYNC:   resv = 8'he0;
            PM_ADDR_DDS_HI: resv = 8'hfc;
            default: resv = (bus_i.addr > PM_ADDR_MODE ||
                             bus_i.addr[7:2] == 6'h03) ? 8'hff : 8'h00;
        endcase
    end
    // A status clear or mask change may legally drop the level
    assign clr = bus_i.wr && (bus_i.addr == PM_ADDR_IRQ_STAT ||
                              bus_i.addr == PM_ADDR_IRQ_MASK);

    sequence manual_edge;
        bus_i.wr && bus_i.addr == PM_ADDR_CTRL &&
        bus_i.wdata[PM_CTRL_MANUAL_BIT] && !ctrl_r[PM_CTRL_MANUAL_BIT];
    endsequence

    ////////////////////////////////////////
    rd_idle_a:
        assert property (!bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data not zero outside answer");
    resv_bits_a:
        assert property (bus_i.rd |=> (rdata_o & $past(resv)) == 8'h00)
        else $error("unused bits read nonzero");
    ctrl_back_a:
        assert property (bus_i.rd && bus_i.addr == PM_ADDR_CTRL
                         |=> rdata_o[1:0] == $past(ctrl_r))
        else $error("control readback wrong");
    mask_back_a:
        assert property (bus_i.rd && bus_i.addr == PM_ADDR_IRQ_MASK
                         |=> rdata_o[1:0] == $past(mask_r))
        else $error("mask readback wrong");
    mode_back_a:
        assert property (bus_i.rd && bus_i.addr == PM_ADDR_MODE
                         |=> rdata_o[2:0] == $past(mode_r))
        else $error("mode readback wrong");
    snap_irq_a:
        assert property (manual_edge ##0 mask_r[PM_IRQ_SNAP_BIT]
                         |-> ##2 irq_o)
        else $error("no interrupt after manual refresh");
    irq_hold_a:
        assert property (irq_o && !clr && !$past(clr) |=> irq_o)
        else $error("interrupt dropped without clear");
    irq_off_a:
        assert property (bus_i.wr && bus_i.addr == PM_ADDR_IRQ_MASK &&
                         bus_i.wdata[1:0] == 2'b00 |-> ##2 !irq_o)
        else $error("interrupt high while masked");
endmodule

bind pm_perf_monitor pm_checker i_pm_checker (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .bus_i      (bus_i),
    .rdata_o    (rdata_o),
    .events_i   (events_i),
    .irq_o      (irq_o)
);

// ---- tb/tb_top.sv ----
// Self-checking bench for the perf monitor snapshot block.
// Drives the register port and event strobes directly.
`timescale 1ns/1ps
module tb_top
    import pm_pkg::*;
;
    localparam int AUTO = 50; // Short refresh period for simulation
    logic        clk = 1'b0;
    logic        rst;
    pm_bus_s     bus;
    pm_events_s  ev;
    logic [7:0]  rdata;
    logic        irq;
    int          n_errors;
    int          check_count;
    logic [15:0] cnt [9];
    logic [15:0] e [7];

    pm_perf_monitor #(
        .AUTO_CYCLES (AUTO)
    ) i_pm_perf_monitor (
        .core_clk_i (clk),
        .reset_i    (rst),
        .bus_i      (bus),
        .rdata_o    (rdata),
        .events_i   (ev),
        .irq_o      (irq)
    );

    // 40 MHz clock
    always #12.5 clk = ~clk;

    ////////////////////////////////////////
    task automatic close_out();
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 cmp(rdata, x);
    endtask

    task automatic snap();
        wr(PM_ADDR_CTRL, 8'h00);
        wr(PM_ADDR_CTRL, 8'h02);
    endtask

    // Pulse each strobe field k for cnt[k] cycles, all from the start
    task automatic run_ev(input int n);
        pm_events_s v;
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 9; k++)
                v[8 - k] = (cnt[k] > i);
            @(posedge clk);
            ev <= v;
        end
        @(posedge clk);
        ev <= '0;
    endtask

    task automatic chk_all();
        rd(PM_ADDR_CRC_LO, e[0][7:0]);
        rd(PM_ADDR_CRC_HI, {2'b00, e[0][9:8], 4'h0});
        rd(PM_ADDR_FBE_LO, e[1][7:0]);
        rd(PM_ADDR_FBE_HI, {4'h0, e[1][11:8]});
        rd(PM_ADDR_ALIGN, e[2][7:0]);
        rd(PM_ADDR_SYNC, e[3][7:0]);
        rd(PM_ADDR_PAT_LO, e[4][7:0]);
        rd(PM_ADDR_PAT_HI, e[4][15:8]);
        rd(PM_ADDR_LCV_LO, e[5][7:0]);
        rd(PM_ADDR_LCV_HI, e[5][15:8]);
        rd(PM_ADDR_DDS_LO, e[6][7:0]);
        rd(PM_ADDR_DDS_HI, {6'h00, e[6][9:8]});
    endtask

    ////////////////////////////////////////
    task automatic s_reset_regs();
        e = '{default: 16'h0000};
        chk_all();
        for (int a = 12; a < 20; a++)
            rd(8'(a), 8'h00);
        rd(8'h20, 8'h00);
        wr(PM_ADDR_CRC_LO, 8'hff);
        rd(PM_ADDR_CRC_LO, 8'h00);
    endtask

    // Every format and decoding, with saturating short fields
    task automatic s_formats();
        cnt = '{16'h0203, 16'h0009, 16'h0105, 16'h000a, 16'h0028,
                16'h012c, 16'h0007, 16'h0003, 16'h0105};
        for (int f = 0; f < 4; f++) begin
            wr(PM_ADDR_MODE, {5'h00, f[0], f[1:0]});
            rd(PM_ADDR_MODE, {5'h00, f[0], f[1:0]});
            run_ev(515);
            snap();
            e[0] = (f == 1) ? cnt[0] : 16'h0000;
            e[1] = (f == 1) ? cnt[2] : cnt[1];
            e[2] = (16'h0001 << PM_W_ALIGN) - 16'h0001;
            e[3] = (16'h0001 << PM_W_SYNC) - 16'h0001;
            e[4] = cnt[5];
            e[5] = f[0] ? cnt[7] : cnt[6];
            e[6] = (f == 2) ? cnt[8] : 16'h0000;
            chk_all();
        end
        // Snapshot taken and a short field saturated: both sticky bits
        rd(PM_ADDR_IRQ_STAT, 8'h03);
    endtask

    task automatic s_hold();
        run_ev(515);
        wr(PM_ADDR_CTRL, 8'h02);
        chk_all();
        snap();
        chk_all();
    endtask

    // Event in the refresh cycle belongs to the next interval
    task automatic s_edge();
        wr(PM_ADDR_CTRL, 8'h00);
        @(posedge clk);
        bus <= '{PM_ADDR_CTRL, 8'h02, 1'b1, 1'b0};
        ev.sync_loss <= 1'b1;
        @(posedge clk);
        bus <= '0;
        ev.sync_loss <= 1'b0;
        rd(PM_ADDR_SYNC, 8'h00);
        snap();
        rd(PM_ADDR_SYNC, 8'h01);
    endtask

    task automatic s_irq();
        wr(PM_ADDR_IRQ_STAT, 8'h03);
        wr(PM_ADDR_IRQ_MASK, 8'h01);
        rd(PM_ADDR_IRQ_MASK, 8'h01);
        rd(PM_ADDR_IRQ_STAT, 8'h00);
        cmp1(irq, 1'b0);
        snap();
        @(posedge clk);
        #1 cmp1(irq, 1'b1);
        rd(PM_ADDR_IRQ_STAT, 8'h01);
        wr(PM_ADDR_IRQ_MASK, 8'h00);
        @(posedge clk);
        #1 cmp1(irq, 1'b0);
        wr(PM_ADDR_IRQ_MASK, 8'h01);
        @(posedge clk);
        #1 cmp1(irq, 1'b1);
        wr(PM_ADDR_IRQ_STAT, 8'h01);
        @(posedge clk);
        #1 cmp1(irq, 1'b0);
        rd(PM_ADDR_IRQ_STAT, 8'h00);
    endtask

    // Periodic refresh; bounded polling guards against a hang
    task automatic s_auto();
        int k;
        cnt = '{default: 16'h0000};
        cnt[5] = 16'h0003;
        wr(PM_ADDR_CTRL, 8'h01);
        run_ev(3);
        for (k = 0; k < AUTO + 10 && irq !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        cmp1(irq, 1'b1);
        rd(PM_ADDR_PAT_LO, 8'h03);
        wr(PM_ADDR_IRQ_STAT, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        for (k = 0; k < AUTO + 10 && irq !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        cmp1(irq && k > AUTO / 2, 1'b1);
        rd(PM_ADDR_PAT_LO, 8'h00);
        wr(PM_ADDR_CTRL, 8'h00);
    endtask

    ////////////////////////////////////////
    initial begin
        #(25 * 12000);
        n_errors++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        bus = '0;
        ev = '0;
        n_errors = 0;
        check_count = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        s_reset_regs();
        s_formats();
        s_hold();
        s_edge();
        s_irq();
        s_auto();
        close_out();
    end
endmodule
